// ### hcrs_defs.vh
// Constants for the host commanded reboot sequencer
`ifndef HCRS_DEFS_VH
`define HCRS_DEFS_VH
`define HCRS_RESTART_CONTROL_ADDR 8'ha2
`define HCRS_REQUEST_BIT          0
`define HCRS_PENDING_BIT          1
`define HCRS_WAIT_SEL_LSB         2
`define HCRS_WAIT_SEL_MSB         4
`define HCRS_CONTROL_RESET        8'h00
`define HCRS_BASE_WAIT_MS         512
`define HCRS_CLK_HZ               50000000
`define HCRS_BASE_WAIT_CYCLES     (`HCRS_BASE_WAIT_MS * (`HCRS_CLK_HZ / 1000))
`endif

// ### hcrs_nv_model.sv
// Nonvolatile store model answering reload requests
module hcrs_nv_model (
  input  wire clk_sys_in,
  input  wire rstn_in,
  input  wire start_in,
  output reg  done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Reload latency
  // ****
  reg [2:0] stage;
  // Copy takes three cycles, then one done pulse
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage    <= 3'h0;
      done_out <= 1'b0;
    end else begin
      stage    <= {stage[1:0], start_in};
      done_out <= stage[2];
    end
  end
endmodule

// ### hcrs_seq_props.sv
// Checker for the reboot sequencer ports
module hcrs_seq_props (
  input wire       clk_sys_in,
  input wire       rstn_in,
  input wire       reg_write_in,
  input wire       reg_read_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire       reload_done_in,
  input wire       reload_start_out,
  input wire       switch_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Assertions
  // ****
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire ctl = reg_addr_in == 8'ha2;
  reg  req;
  always @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in) req <= 1'b0;
    else if (reg_write_in && ctl) req <= reg_wdata_in[0];
  chk_req_off: assert property (reg_write_in && ctl && reg_wdata_in[0] && !req && switch_enable_out
    |-> ##2 !switch_enable_out) else $error("switch not off after request");
  chk_wait_off: assert property ($fell(switch_enable_out) |-> !switch_enable_out [*3])
    else $error("switch back on too soon");
  chk_reload_off: assert property (reload_start_out |-> !switch_enable_out && !$past(reload_start_out))
    else $error("bad reload pulse");
  chk_on_done: assert property (reload_done_in && !switch_enable_out |=> switch_enable_out)
    else $error("switch not on after reload");
  chk_req_kept: assert property (reg_read_in && ctl |=> reg_rdata_out[0] == $past(req))
    else $error("request bit read wrong");
  chk_pend_idle: assert property (reg_read_in && ctl && switch_enable_out |=> !reg_rdata_out[1])
    else $error("pending set while on");
  chk_unmapped_zero: assert property (reg_read_in && !ctl |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_no_restart: assert property (reg_write_in && ctl && req && switch_enable_out |-> ##2 switch_enable_out)
    else $error("restart without rising request");
  cover property (reload_start_out);
  cover property ($rose(switch_enable_out));
  cover property (reg_read_in && !ctl);
endmodule

// ### hcrs_sequencer.v
// Reboot sequencer: restart control register, output switch off, wait, reload
//
// Summary of operation
// - Restart request bit lives in restart control register at address 0xa2.
// - Writing request from zero to one while on turns switches off; restart after wait elapses.
// - Three-bit wait select sets delay from 512 ms up to 65.5 s.
// - Wait pending flag reads one during the wait, clears itself after.
// - Each reboot reloads volatile registers from nonvolatile store, as power-up.
// - Hardware never clears the request bit; it still reads one afterwards.
`include "hcrs_defs.vh"
module hcrs_sequencer #(
  parameter BASE_CYCLES = `HCRS_BASE_WAIT_CYCLES
) (
  input  wire       clk_sys_in,
  input  wire       rstn_in,
  input  wire       reg_write_in,
  input  wire       reg_read_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  output reg  [7:0] reg_rdata_out,
  input  wire       reload_done_in,
  output reg        reload_start_out,
  output reg        switch_enable_out
);
  localparam [1:0] ST_ON     = 2'h0;
  localparam [1:0] ST_WAIT   = 2'h1;
  localparam [1:0] ST_RELOAD = 2'h2;

  reg [1:0] state;
  reg       restart_request;
  reg       request_prev;
  reg [2:0] restart_wait_select;
  wire      wait_busy;
  wire      wait_done;
  wire      hit = (reg_addr_in == `HCRS_RESTART_CONTROL_ADDR);
  wire      start_wait = (state == ST_ON) && restart_request && !request_prev;

  // ****************
  // Register access
  // ****************
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      restart_request     <= 1'b0;
      restart_wait_select <= 3'h0;
      request_prev        <= 1'b0;
      reg_rdata_out       <= 8'h00;
    end else begin
      request_prev <= restart_request;
      if (reg_write_in && hit) begin
        restart_request     <= reg_wdata_in[`HCRS_REQUEST_BIT];
        restart_wait_select <= reg_wdata_in[`HCRS_WAIT_SEL_MSB:`HCRS_WAIT_SEL_LSB];
      end
      if (reg_read_in) begin
        if (hit) begin
          reg_rdata_out <= {3'h0, restart_wait_select, wait_busy, restart_request};
        end else begin
          reg_rdata_out <= 8'h00;
        end
      end
    end
  end

  hcrs_wait_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_wait (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .start_in   (start_wait),
    .select_in  (restart_wait_select),
    .busy_out   (wait_busy),
    .done_out   (wait_done)
  );

  // ********************
  // Reboot state machine
  // ********************
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state             <= ST_ON;
      switch_enable_out <= 1'b1;
      reload_start_out  <= 1'b0;
    end else begin
      reload_start_out <= 1'b0;
      case (state)
        ST_ON: begin
          // Rising edge only, so a request left at one does not loop
          if (start_wait) begin
            state             <= ST_WAIT;
            switch_enable_out <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state            <= ST_RELOAD;
            reload_start_out <= 1'b1;
          end
        end
        ST_RELOAD: begin
          if (reload_done_in) begin
            state             <= ST_ON;
            switch_enable_out <= 1'b1;
          end
        end
        default: begin
          state <= ST_ON;
        end
      endcase
    end
  end
endmodule

// ### hcrs_sequencer_tb.sv
// Testbench for the reboot sequencer
module hcrs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench
  // ****
  reg        clk_sys_in = 1'b0;
  reg        rstn_in = 1'b0;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg  [7:0] d;
  wire [7:0] rdata;
  wire       done;
  wire       start;
  wire       sw;
  integer    failures = 0;
  integer    num_checks = 0;
  integer    c;
  integer    n;
  hcrs_sequencer #(.BASE_CYCLES(4)) DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_write_in(wr),
    .reg_read_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reload_done_in(done), .reload_start_out(start), .switch_enable_out(sw));
  hcrs_nv_model NV (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .start_in(start), .done_out(done));
  initial forever #10 clk_sys_in = ~clk_sys_in;
  task check(input [7:0] seen, input [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wreg(input [7:0] a, input [7:0] v);
    @(negedge clk_sys_in); wr = 1'b1; addr = a; wdata = v;
    @(negedge clk_sys_in); wr = 1'b0;
  endtask
  task rreg(input [7:0] a);
    @(negedge clk_sys_in); rd = 1'b1; addr = a;
    @(negedge clk_sys_in); rd = 1'b0; d = rdata;
  endtask
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000; failures++; report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in); rstn_in = 1'b1;
    rreg(8'ha2); check(d, 8'h00);
    for (n = 0; n < 8; n++) begin
      wreg(8'ha2, 8'h00);
      wreg(8'ha2, {3'h0, n[2:0], 2'h1});
      @(negedge clk_sys_in); rreg(8'ha2); check(d, {3'h0, n[2:0], 2'h3});
      for (c = 4; start !== 1'b1 && c < 2000; c++) @(negedge clk_sys_in);
      check({7'h0, c >= (4 << n) && c <= (4 << n) + 3}, 8'h01);
      check({7'h0, sw}, 8'h00);
      for (c = 0; sw !== 1'b1 && c < 50; c++) @(negedge clk_sys_in);
      rreg(8'ha2); check(d, {3'h0, n[2:0], 2'h1});
    end
    wreg(8'ha2, 8'h01); repeat (5) @(negedge clk_sys_in); check({7'h0, sw}, 8'h01);
    rreg(8'h10); check(d, 8'h00);
    report_and_stop;
  end
endmodule
bind hcrs_sequencer hcrs_seq_props P (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reload_done_in(reload_done_in), .reload_start_out(reload_start_out), .switch_enable_out(switch_enable_out));

// ### hcrs_wait_timer.v
// Programmable doubling wait timer
`include "hcrs_defs.vh"
module hcrs_wait_timer #(
  parameter BASE_CYCLES = `HCRS_BASE_WAIT_CYCLES
) (
  input  wire       clk_sys_in,
  input  wire       rstn_in,
  input  wire       start_in,
  input  wire [2:0] select_in,
  output reg        busy_out,
  output reg        done_out
);
  reg [31:0] base_count;
  // Wide enough to count the 128 intervals of the longest wait
  reg [7:0]  steps_left;
  localparam [31:0] BASE_LAST = BASE_CYCLES - 1;

  // **************************************
  // Base interval times two to the select
  // **************************************
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      base_count <= 32'h0000_0000;
      steps_left <= 8'h00;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out   <= 1'b1;
        base_count <= 32'h0000_0000;
        steps_left <= 8'h00;
      end else if (busy_out) begin
        if (base_count == BASE_LAST) begin
          base_count <= 32'h0000_0000;
          // Ends after interval index 2^n-1, so 2^n intervals in all
          if (steps_left == ((8'h01 << select_in) - 8'h01)) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
          steps_left <= steps_left + 8'h01;
        end else begin
          base_count <= base_count + 32'h0000_0001;
        end
      end
    end
  end
endmodule
